//--- otuc_pkg.sv
// otuc_pkg: constants and helpers for the fault-limit command block
// assumes a single 250 MHz core clock and linear-11 coded words on all limit and measurement ports
package otuc_pkg;
   // ----------------------------------------------------------------
   // command codes
   // ----------------------------------------------------------------
   localparam logic [7:0] CMD_VALLEY_UC_LIMIT = 8'h4B;
   localparam logic [7:0] CMD_OT_LIMIT = 8'h4F;
   localparam logic [7:0] CMD_OT_ACTION = 8'h50;

   // ----------------------------------------------------------------
   // field layout of limit words and of the action byte
   // ----------------------------------------------------------------
   localparam int EXP_MSB = 15;
   localparam int EXP_LSB = 11;
   localparam int MANT_MSB = 10;
   localparam int ACT_MODE_MSB = 7;
   localparam int ACT_MODE_LSB = 6;
   localparam int ACT_RETRY_MSB = 5;
   localparam int ACT_RETRY_LSB = 3;
   localparam int ACT_DELAY_MSB = 2;
   localparam logic [1:0] MODE_DISABLE_RETRY = 2'h2;
   localparam int VENDOR_OT_BIT = 1;

   // ----------------------------------------------------------------
   // values after reset (none given, plain defaults)
   // ----------------------------------------------------------------
   localparam logic [15:0] UC_LIMIT_RST = 16'h0000;
   localparam logic [15:0] OT_LIMIT_RST = 16'h007D;
   localparam logic [7:0] OT_ACTION_RST = 8'hB8;

   // ----------------------------------------------------------------
   // timing: retry time unit
   // ----------------------------------------------------------------
   localparam longint CLK_HZ = 250000000;
   localparam longint RETRY_UNIT_MS = 35;
   localparam longint RETRY_UNIT_CYC = (CLK_HZ / 1000) * RETRY_UNIT_MS;

   // fixed point: value scaled by 2^16, wide enough for mantissa << 31
   localparam int FIX_W = 48;
   localparam int FIX_FRAC = 16;

   typedef enum logic [1:0] {
      OTUC_RUN = 2'b00,
      OTUC_WAIT = 2'b01,
      OTUC_OFF = 2'b10
   } otuc_state_t;

   // linear-11 word to signed fixed point
   function automatic logic signed [FIX_W-1:0] otuc_lin2fix(input logic [15:0] w);
      logic signed [4:0] e;
      logic signed [FIX_W-1:0] m;
      logic signed [5:0] sh;
      e = w[EXP_MSB:EXP_LSB];
      m = FIX_W'(signed'(w[MANT_MSB:0]));
      sh = 6'(e) + 6'(FIX_FRAC);
      otuc_lin2fix = m <<< sh[4:0];
      if (sh[5]) begin
         otuc_lin2fix = m >>> 6'(-sh);
      end else if (sh[5:0] > 6'd31) begin
         otuc_lin2fix = m <<< 6'(sh);
      end
   endfunction : otuc_lin2fix
endpackage : otuc_pkg

//--- otuc_fault_limits.sv
// otuc_fault_limits: valley undercurrent and over-temperature fault limits with retry timing
// assumes a command port decoded upstream from the management bus, and measurements in linear-11
// Notes on behaviour
// - valley undercurrent limit stored at code 4B, valley current compared against it
// - valley undercurrent sets shared undercurrent flag and uses shared response setting
// - out-of-range limit writes are refused, stored limit kept
// - temperature limit is mantissa times two to the exponent, in Celsius
// - temperature limit stored at code 4F, exceeding it raises a fault
// - retry waits until temperature falls below warning limit
// - fault sets status word temperature bit, temperature status bit, alerts host
// - fault also sets bit 1 of vendor status byte
// - action byte at code 50 picks response, delay runs from detection
// - retry delay counts in 35 ms units
`timescale 1ns/10ps
module otuc_fault_limits
   import otuc_pkg::*;
#(
   parameter longint UNIT_CYCLES = RETRY_UNIT_CYC,
   parameter logic [15:0] UC_MIN = 16'h0000,
   parameter logic [15:0] UC_MAX = 16'h00C8,
   parameter logic [15:0] OT_MIN = 16'h0000,
   parameter logic [15:0] OT_MAX = 16'h0096
) (
   input wire logic core_clk, // 250 MHz core clock
   input wire logic rstn, // asynchronous reset, active low
   input wire logic cmd_wr, // write strobe, one cycle
   input wire logic [7:0] cmd_code, // command code for read or write
   input wire logic [15:0] cmd_wdata, // write data
   output logic [15:0] cmd_rdata, // read data of cmd_code, one cycle late
   output logic cmd_ack, // write taken, pulse
   output logic cmd_nack, // write refused, pulse
   input wire logic [15:0] valley_current, // valley output current, linear-11
   input wire logic avg_undercurrent, // averaged undercurrent detection, level
   input wire logic [7:0] undercurrent_fault_action, // shared undercurrent response byte
   input wire logic [15:0] temperature, // measured temperature, linear-11
   input wire logic [15:0] overtemp_warning_limit, // warning limit, linear-11
   input wire logic clear_faults, // clear all sticky flags, pulse
   output logic undercurrent_flag, // undercurrent bit of output current status
   output logic undercurrent_shutdown, // output disabled by undercurrent
   output logic status_word_temperature, // temperature summary bit of status word
   output logic overtemp_fault_flag, // fault bit of temperature status
   output logic [7:0] vendor_status_byte, // vendor status byte
   output logic alert_n, // host alert, active low
   output logic output_enable, // converter may run
   output logic retry_start // restart attempt, pulse
);
   // ----------------------------------------------------------------
   // parameter checks
   // ----------------------------------------------------------------
   if (UNIT_CYCLES < 1 || UNIT_CYCLES > 64'd16777215) begin : g_bad_unit
      $error("UNIT_CYCLES out of range");
   end

   // ----------------------------------------------------------------
   // storage
   // ----------------------------------------------------------------
   logic [15:0] uc_limit_reg;
   logic [15:0] ot_limit_reg;
   logic [7:0] ot_action_reg;
   logic [15:0] rdata_reg;
   logic ack_reg;
   logic nack_reg;
   logic uc_flag_reg;
   logic uc_off_reg;
   logic ot_flag_reg;
   logic alert_reg;
   logic ot_cond_reg;
   logic uc_cond_reg;
   otuc_state_t state_reg;
   otuc_state_t state_next;
   logic [23:0] tick_cnt_reg;
   logic [3:0] unit_cnt_reg;
   logic retry_reg;

   // ----------------------------------------------------------------
   // write decode and range checks
   // ----------------------------------------------------------------
   // decoded words compared in fixed point so exponent choice does not matter
   wire logic signed [FIX_W-1:0] wr_fix = otuc_lin2fix(cmd_wdata);
   wire logic uc_in_range = wr_fix >= otuc_lin2fix(UC_MIN) && wr_fix <= otuc_lin2fix(UC_MAX);
   wire logic ot_in_range = wr_fix >= otuc_lin2fix(OT_MIN) && wr_fix <= otuc_lin2fix(OT_MAX);
   wire logic hit_uc = cmd_wr && cmd_code == CMD_VALLEY_UC_LIMIT;
   wire logic hit_ot = cmd_wr && cmd_code == CMD_OT_LIMIT;
   wire logic hit_act = cmd_wr && cmd_code == CMD_OT_ACTION;
   wire logic wr_ok = (hit_uc && uc_in_range) || (hit_ot && ot_in_range) || hit_act;
   wire logic wr_bad = cmd_wr && !wr_ok;
   wire logic [15:0] rd_mux = (cmd_code == CMD_VALLEY_UC_LIMIT) ? uc_limit_reg :
                              (cmd_code == CMD_OT_LIMIT) ? ot_limit_reg :
                              (cmd_code == CMD_OT_ACTION) ? {8'h00, ot_action_reg} : 16'h0000;

   // limit registers, refused writes leave the old value
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         uc_limit_reg <= UC_LIMIT_RST;
         ot_limit_reg <= OT_LIMIT_RST;
         ot_action_reg <= OT_ACTION_RST;
      end else begin
         if (hit_uc && uc_in_range) uc_limit_reg <= cmd_wdata;
         if (hit_ot && ot_in_range) ot_limit_reg <= cmd_wdata;
         if (hit_act) ot_action_reg <= cmd_wdata[7:0];
      end
   end

   // read data and write answers, registered
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         rdata_reg <= 16'h0000;
         ack_reg <= 1'b0;
         nack_reg <= 1'b0;
      end else begin
         rdata_reg <= rd_mux;
         ack_reg <= wr_ok;
         nack_reg <= wr_bad;
      end
   end

   // ----------------------------------------------------------------
   // fault detection
   // ----------------------------------------------------------------
   // temperature in Celsius as mantissa times 2^exponent
   wire logic signed [FIX_W-1:0] temp_fix = otuc_lin2fix(temperature);
   wire logic ot_cond = temp_fix > otuc_lin2fix(ot_limit_reg);
   wire logic below_warn = temp_fix < otuc_lin2fix(overtemp_warning_limit);
   wire logic valley_uc = otuc_lin2fix(valley_current) < otuc_lin2fix(uc_limit_reg);
   wire logic uc_cond = valley_uc || avg_undercurrent;
   // only a fresh crossing counts, so a long fault is one event
   wire logic ot_event = ot_cond && !ot_cond_reg;
   wire logic uc_event = uc_cond && !uc_cond_reg;
   wire logic uc_acts = undercurrent_fault_action[ACT_MODE_MSB:ACT_MODE_LSB] != 2'h0;

   // sticky flags, a new event wins over clear_faults
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         ot_cond_reg <= 1'b0;
         uc_cond_reg <= 1'b0;
         uc_flag_reg <= 1'b0;
         uc_off_reg <= 1'b0;
         ot_flag_reg <= 1'b0;
         alert_reg <= 1'b0;
      end else begin
         ot_cond_reg <= ot_cond;
         uc_cond_reg <= uc_cond;
         if (uc_event) begin
            uc_flag_reg <= 1'b1;
            alert_reg <= 1'b1;
            if (uc_acts) uc_off_reg <= 1'b1;
         end else if (clear_faults) begin
            uc_flag_reg <= 1'b0;
            uc_off_reg <= 1'b0;
         end
         if (ot_event) begin
            ot_flag_reg <= 1'b1;
            alert_reg <= 1'b1;
         end else if (clear_faults) begin
            ot_flag_reg <= 1'b0;
         end
         if (clear_faults && !ot_event && !uc_event) alert_reg <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // over-temperature response and retry timing
   // ----------------------------------------------------------------
   wire logic [1:0] act_mode = ot_action_reg[ACT_MODE_MSB:ACT_MODE_LSB];
   wire logic act_retry = ot_action_reg[ACT_RETRY_MSB:ACT_RETRY_LSB] != 3'h0;
   wire logic [3:0] delay_units = {1'b0, ot_action_reg[ACT_DELAY_MSB:0]} + 4'h1;
   wire logic unit_tick = tick_cnt_reg == 24'(UNIT_CYCLES - 1);
   wire logic delay_done = unit_cnt_reg >= delay_units;
   wire logic go_retry = state_reg == OTUC_WAIT && delay_done && below_warn;

   // next state: mode 00 ignores the fault, others disable
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         OTUC_RUN: begin
            if (ot_event && act_mode != 2'h0) begin
               state_next = (act_mode == MODE_DISABLE_RETRY && act_retry) ? OTUC_WAIT : OTUC_OFF;
            end
         end
         OTUC_WAIT: begin
            if (go_retry) state_next = OTUC_RUN;
         end
         OTUC_OFF: begin
            if (clear_faults && !ot_event) state_next = OTUC_RUN;
         end
         default: state_next = OTUC_RUN;
      endcase
   end

   // delay counter restarts at fault detection; stalls at the end while hot
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         state_reg <= OTUC_RUN;
         tick_cnt_reg <= 24'h000000;
         unit_cnt_reg <= 4'h0;
         retry_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         retry_reg <= go_retry;
         if (state_reg != OTUC_WAIT || unit_tick) tick_cnt_reg <= 24'h000000;
         else tick_cnt_reg <= tick_cnt_reg + 24'h000001;
         if (state_reg != OTUC_WAIT) unit_cnt_reg <= 4'h0;
         else if (unit_tick && !delay_done) unit_cnt_reg <= unit_cnt_reg + 4'h1;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign cmd_rdata = rdata_reg;
   assign cmd_ack = ack_reg;
   assign cmd_nack = nack_reg;
   assign undercurrent_flag = uc_flag_reg;
   assign undercurrent_shutdown = uc_off_reg;
   assign status_word_temperature = ot_flag_reg;
   assign overtemp_fault_flag = ot_flag_reg;
   assign vendor_status_byte = {6'h00, ot_flag_reg, 1'b0};
   assign alert_n = !alert_reg;
   assign output_enable = state_reg == OTUC_RUN && !uc_off_reg;
   assign retry_start = retry_reg;
endmodule : otuc_fault_limits

//--- otuc_fault_limits_props.sv
// otuc_fault_limits_props: port-level checks of the fault-limit block
// assumes it is bound onto otuc_fault_limits with linear-11 exponent 0 writes
`timescale 1ns/10ps
module otuc_fault_limits_props
   import otuc_pkg::*;
#(
   parameter logic [15:0] OT_MAX = 16'h0096
) (
   input wire logic core_clk, // clock
   input wire logic rstn, // reset, low
   input wire logic cmd_wr, // strobe
   input wire logic [7:0] cmd_code, // code
   input wire logic [15:0] cmd_wdata, // data
   input wire logic cmd_ack, // taken
   input wire logic cmd_nack, // refused
   input wire logic [15:0] temperature, // temp
   input wire logic [15:0] overtemp_warning_limit, // warn
   input wire logic overtemp_fault_flag, // ot flag
   input wire logic status_word_temperature, // summary
   input wire logic [7:0] vendor_status_byte, // vendor
   input wire logic alert_n, // alert
   input wire logic output_enable, // run
   input wire logic undercurrent_shutdown, // uc off
   input wire logic retry_start // restart
);
   // one domain, so clock and reset are given once
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);
   sequence s_overtemp_fault_flag; $rose(overtemp_fault_flag); endsequence
   sequence s_ot_high; cmd_wr && cmd_code == CMD_OT_LIMIT && cmd_wdata[15:10] == 6'h00 && cmd_wdata > OT_MAX; endsequence
   sequence s_retry; retry_start ##0 output_enable ##1 !retry_start; endsequence
   property p_wr_answer; cmd_wr |=> cmd_ack != cmd_nack; endproperty
   a_wr_answer: assert property (p_wr_answer) else $error("write not answered once");
   property p_ot_nack; s_ot_high |=> cmd_nack; endproperty
   a_ot_nack: assert property (p_ot_nack) else $error("high limit taken");
   property p_action_ack; cmd_wr && cmd_code == CMD_OT_ACTION |=> cmd_ack; endproperty
   a_action_ack: assert property (p_action_ack) else $error("action write refused");
   property p_ot_status; s_overtemp_fault_flag |-> status_word_temperature && !alert_n; endproperty
   a_ot_status: assert property (p_ot_status) else $error("fault not reported");
   property p_vendor; vendor_status_byte == {6'h00, overtemp_fault_flag, 1'b0}; endproperty
   a_vendor: assert property (p_vendor) else $error("vendor byte wrong");
   property p_delay; s_overtemp_fault_flag |-> !retry_start [*3]; endproperty
   a_delay: assert property (p_delay) else $error("retry too soon");
   // retry only once cooled below the warning level seen at the deciding edge
   property p_cool; retry_start |-> otuc_lin2fix($past(temperature)) < otuc_lin2fix($past(overtemp_warning_limit)); endproperty
   a_cool: assert property (p_cool) else $error("retry while hot");
   property p_retry; retry_start |-> s_retry; endproperty
   a_retry: assert property (p_retry) else $error("retry pulse wrong");
   property p_uc_off; undercurrent_shutdown |-> !output_enable; endproperty
   a_uc_off: assert property (p_uc_off) else $error("runs in shutdown");
endmodule : otuc_fault_limits_props
bind otuc_fault_limits otuc_fault_limits_props #(.OT_MAX(OT_MAX)) u_props (.*);

//--- otuc_host_model.sv
// otuc_host_model: management bus host on the command port
// assumes answers one cycle after each write strobe
`timescale 1ns/10ps
module otuc_host_model (
   input wire logic core_clk, // clock
   input wire logic cmd_ack, // taken
   input wire logic cmd_nack, // refused
   input wire logic [15:0] cmd_rdata, // read data
   output logic cmd_wr, // strobe
   output logic [7:0] cmd_code, // code
   output logic [15:0] cmd_wdata, // data
   output logic [15:0] overtemp_warning_limit // warn level
);
   initial begin
      cmd_wr = 1'b0;
      cmd_code = 8'h00;
      cmd_wdata = 16'h0000;
      overtemp_warning_limit = 16'h005A; // 90 C, kept under the fault level
   end
   // write, then keep the code selected to read it back
   task automatic wr(input logic [7:0] c, input logic [15:0] d, output logic a, output logic n, output logic [15:0] r);
      @(posedge core_clk);
      cmd_wr <= 1'b1;
      cmd_code <= c;
      cmd_wdata <= d;
      @(posedge core_clk);
      cmd_wr <= 1'b0;
      cmd_wdata <= ~d; // released data never looks valid
      #1 a = cmd_ack;
      n = cmd_nack;
      @(posedge core_clk);
      #1 r = cmd_rdata;
   endtask : wr
endmodule : otuc_host_model

//--- otuc_fault_limits_test.sv
// otuc_fault_limits_test: self-checking bench of the fault-limit block
// assumes a retry unit shortened to 4 cycles and exponent 0 measurements
`timescale 1ns/10ps
module otuc_fault_limits_test;
   import otuc_pkg::*;
   logic core_clk = 1'b0, rstn = 1'b0, clear_faults = 1'b0, avg_undercurrent = 1'b0;
   logic [7:0] undercurrent_fault_action = 8'h80;
   logic [15:0] valley_current = 16'h0064, temperature = 16'h0032;
   logic cmd_wr, cmd_ack, cmd_nack, undercurrent_flag, undercurrent_shutdown, status_word_temperature;
   logic overtemp_fault_flag, alert_n, output_enable, retry_start;
   logic [7:0] cmd_code, vendor_status_byte;
   logic [15:0] cmd_wdata, cmd_rdata, overtemp_warning_limit;
   int n_mismatch = 0, cmp_count = 0, cyc = 0;
   always #2 core_clk = ~core_clk;
   // hang guard, well above the roughly 150 cycles needed
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         n_mismatch++;
         report_and_stop();
      end
   end
   otuc_host_model host (.*);
   otuc_fault_limits #(.UNIT_CYCLES(4)) DUT (.*);
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
      cmp_count++;
      if (s !== e) begin
         n_mismatch++;
         $display("BAD %s exp %h got %h", nm, e, s);
      end
   endtask : chk
   task automatic clr();
      @(posedge core_clk) clear_faults <= 1'b1;
      @(posedge core_clk) clear_faults <= 1'b0;
      repeat (2) @(negedge core_clk);
   endtask : clr
   // limit writes at range edges, exponent form, unknown code, action byte
   task automatic t_limits();
      logic [7:0] c[8] = '{8'h4F, 8'h4F, 8'h4F, 8'h51, 8'h4B, 8'h4B, 8'h4B, 8'h50};
      logic [15:0] d[8] = '{16'h0097, 16'h0850, 16'h0832, 16'h0001, 16'h00C9, 16'h00C8, 16'h0014, 16'h0089};
      logic [15:0] rb[8] = '{16'h007D, 16'h007D, 16'h0832, 16'h0000, 16'h0000, 16'h00C8, 16'h0014, 16'h0089};
      logic a, n;
      logic [15:0] r;
      for (int i = 0; i < 8; i++) begin
         host.wr(c[i], d[i], a, n, r);
         chk("ack", 16'(rb[i] == d[i]), 16'(a));
         chk("nack", 16'(rb[i] != d[i]), 16'(n));
         chk("readback", rb[i], r);
      end
      // raising the valley limit to 200 A over a 100 A valley is a real undercurrent event
      chk("uc flag", 16'h0001, 16'(undercurrent_flag));
      chk("uc off", 16'h0001, 16'(undercurrent_shutdown));
      clr();
   endtask : t_limits
   // fault at 110 C over a 100 C limit, retry held off while hot
   task automatic t_ot_retry();
      int k = 0;
      @(posedge core_clk) temperature <= 16'h006E;
      repeat (2) @(negedge core_clk);
      chk("ot flag", 16'h0001, 16'(overtemp_fault_flag));
      chk("summary", 16'h0001, 16'(status_word_temperature));
      chk("alert_n", 16'h0000, 16'(alert_n));
      chk("vendor", 16'h0002, 16'(vendor_status_byte));
      chk("run", 16'h0000, 16'(output_enable));
      repeat (20) begin
         @(negedge core_clk);
         if (retry_start !== 1'b0) k++;
      end
      chk("early retry", 16'h0000, 16'(k));
      @(posedge core_clk) temperature <= 16'h0050;
      for (k = 0; k < 30 && retry_start !== 1'b1; k++) @(negedge core_clk);
      chk("retry", 16'h0001, 16'(retry_start));
      chk("run", 16'h0001, 16'(output_enable));
      clr();
      chk("alert_n", 16'h0001, 16'(alert_n));
   endtask : t_ot_retry
   // one hot cycle: retry comes after two units of 4 cycles
   task automatic t_delay();
      int k;
      @(posedge core_clk) temperature <= 16'h006E;
      @(posedge core_clk) temperature <= 16'h0050;
      @(negedge core_clk);
      for (k = 0; k < 5 && overtemp_fault_flag !== 1'b1; k++) @(negedge core_clk);
      for (k = 0; k < 30 && retry_start !== 1'b1; k++) @(negedge core_clk);
      chk("delay", 16'h0001, 16'(k >= 7 && k <= 9));
      clr();
   endtask : t_delay
   // valley below 20 A, then the averaged path on the same flag
   task automatic t_uc();
      @(posedge core_clk) valley_current <= 16'h000A;
      repeat (2) @(negedge core_clk);
      chk("uc flag", 16'h0001, 16'(undercurrent_flag));
      chk("uc off", 16'h0001, 16'(undercurrent_shutdown));
      @(posedge core_clk) valley_current <= 16'h0064;
      clr();
      chk("uc flag", 16'h0000, 16'(undercurrent_flag));
      @(posedge core_clk) avg_undercurrent <= 1'b1;
      repeat (2) @(negedge core_clk);
      chk("avg flag", 16'h0001, 16'(undercurrent_flag));
      @(posedge core_clk) avg_undercurrent <= 1'b0;
      clr();
      chk("run", 16'h0001, 16'(output_enable));
   endtask : t_uc
   // mode 11 stays off until cleared even once cool; mode 00 only flags
   task automatic t_off();
      logic a, n;
      logic [15:0] r;
      int k = 0;
      host.wr(CMD_OT_ACTION, 16'h00C0, a, n, r);
      chk("ack", 16'h0001, 16'(a));
      @(posedge core_clk) temperature <= 16'h006E;
      repeat (2) @(negedge core_clk);
      chk("off run", 16'h0000, 16'(output_enable));
      @(posedge core_clk) temperature <= 16'h0050;
      repeat (20) begin
         @(negedge core_clk);
         if (retry_start !== 1'b0 || output_enable !== 1'b0) k++;
      end
      chk("off held", 16'h0000, 16'(k));
      clr();
      chk("off cleared", 16'h0001, 16'(output_enable));
      host.wr(CMD_OT_ACTION, 16'h0000, a, n, r);
      @(posedge core_clk) temperature <= 16'h006E;
      repeat (2) @(negedge core_clk);
      chk("ignore flag", 16'h0001, 16'(overtemp_fault_flag));
      chk("ignore run", 16'h0001, 16'(output_enable));
      @(posedge core_clk) temperature <= 16'h0050;
      clr();
   endtask : t_off
   task automatic report_and_stop();
      if (n_mismatch == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : report_and_stop
   initial begin
      repeat (20) @(posedge core_clk);
      rstn <= 1'b1;
      t_limits();
      t_ot_retry();
      t_delay();
      t_uc();
      t_off();
      report_and_stop();
   end
endmodule : otuc_fault_limits_test
